// [power_sequence_sleep_control.sv]
// Power sequencing, sleep control and pin supervision with APB registers
// Operation
// - order select picks first-up converter; both go down together
// - core default 1.5 V or 1.8 V strap
// - main default 3.0 V or 3.3 V strap
// - sleep pin ignored while enable bit clear
// - sleep entry on rising edge of AND
// - sleep drives core to preset sleep voltage
// - core off bit disables core in sleep
// - four events end the sleep state
// - sleep pin enters wait; supply needs allow
// - wake button restores pre-sleep core setting
// - button, restart and cover are debounced
// - button activation raises maskable interrupt
// - restart asserts processor reset if core good
// - restart changes no register setting, besides leaving sleep or wait
// - cover high present, low removed
// - cover low raises interrupt, power fail low
// - cover low shuts converters, ldos reduced
// - poweron reset after main good plus delay
// - processor reset held while poweron reset low
`timescale 1ns/1ps
`include "pseq_map.svh"
module power_sequence_sleep_control #(
	parameter int DEBOUNCE_CYCLES = `DEBOUNCE_CYC,
	parameter int POR_SHORT_CYCLES = `POR_SHORT_CYC,
	parameter int POR_LONG_CYCLES = `POR_LONG_CYC
) (
	input wire logic pclk,
	input wire logic presetn,
	input wire logic psel,
	input wire logic penable,
	input wire logic pwrite,
	input wire logic [11:0] paddr,
	input wire logic [31:0] pwdata,
	output logic [31:0] prdata,
	output logic pready,
	output logic pslverr,
	input wire logic sequence_order_select,
	input wire logic core_default_select,
	input wire logic main_default_select,
	input wire logic poweron_delay_select,
	input wire logic sleep_request_pin,
	input wire logic pushbutton_wake,
	input wire logic warm_restart_n,
	input wire logic cover_present,
	input wire logic supply_present,
	input wire logic core_good,
	input wire logic main_good,
	output pseq_pkg::rail_ctrl_t rails,
	output logic poweron_reset_n,
	output logic processor_reset_n,
	output logic power_fail_n,
	output logic irq
);
	localparam int PIN_N = 10;
	logic [PIN_N-1:0] sync_a;
	logic [PIN_N-1:0] sync_b;
	logic [2:0] deb;
	logic [2:0] deb_prev;
	logic [7:0] ctrl_one;
	logic [7:0] ctrl_two;
	logic [7:0] charger_config;
	logic [1:0] irq_pending;
	logic [1:0] irq_mask;
	logic [1:0] saved_vsel;
	logic [1:0] core_vsel;
	logic main_vsel;
	logic straps_taken;
	logic [1:0] strap_wait;
	logic sleep_and_prev;
	logic [31:0] por_count;
	logic por_done;
	pseq_pkg::seq_state_t state;
	logic [1:0] step;
	logic s_seq, s_sleep, s_core_good, s_main_good, s_supply;
	logic button_rise, restart_fall, cover_fall;
	logic sleep_and, sleep_rise;
	logic wr, rd;
	logic first_core;

	// Two-flop synchronisers on every pin input except the delay select
	// Order and default straps pass them too; the delay select pin is read raw
	// Bit 9 main strap, bit 0 core strap
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			sync_a <= '0;
			sync_b <= '0;
		end else begin
			sync_a <= {main_default_select,
				sequence_order_select, sleep_request_pin, core_good,
				main_good, supply_present, pushbutton_wake, warm_restart_n,
				cover_present, core_default_select};
			sync_b <= sync_a;
		end
	end
	assign s_seq = sync_b[8];
	assign s_sleep = sync_b[7];
	assign s_core_good = sync_b[6];
	assign s_main_good = sync_b[5];
	assign s_supply = sync_b[4];

	// Debounce filters: button, restart, cover
	generate
		for (genvar i = 0; i < 3; i++) begin : g_deb
			logic [15:0] cnt;
			logic raw;
			assign raw = sync_b[3-i];
			always_ff @(posedge pclk or negedge presetn) begin
				if (!presetn) begin
					cnt <= '0;
					deb[i] <= (i != 0);
					deb_prev[i] <= (i != 0);
				end else begin
					deb_prev[i] <= deb[i];
					if (raw == deb[i]) begin
						cnt <= '0;
					end else if (cnt == 16'(DEBOUNCE_CYCLES - 1)) begin
						cnt <= '0;
						deb[i] <= raw;
					end else begin
						cnt <= cnt + 16'h0001;
					end
				end
			end
		end
	endgenerate
	assign button_rise = deb[0] & ~deb_prev[0];
	assign restart_fall = ~deb[1] & deb_prev[1];
	assign cover_fall = ~deb[2] & deb_prev[2];

	// Straps caught once after reset release
	// Capture waits two edges so the synchroniser holds the strap level
	// Until then the sequencer stays off
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			straps_taken <= 1'b0;
			strap_wait <= 2'h0;
			main_vsel <= `VSEL_MAIN_3V0;
		end else if (!straps_taken) begin
			if (strap_wait == 2'h2) begin
				straps_taken <= 1'b1;
				main_vsel <= sync_b[9] ? `VSEL_MAIN_3V3
					: `VSEL_MAIN_3V0;
			end else begin
				strap_wait <= strap_wait + 2'h1;
			end
		end
	end

	// APB access decode, zero wait states
	assign wr = psel & penable & pwrite;
	assign rd = psel & ~pwrite;
	assign pready = 1'b1;
	assign pslverr = 1'b0;

	// Software registers
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			ctrl_one <= `CTRL_ONE_RESET;
			ctrl_two <= `CTRL_TWO_RESET;
			charger_config <= `CHARGER_RESET;
			irq_mask <= 2'(`MASK_RESET);
		end else if (wr) begin
			unique case (paddr)
				`CONVERTER_CTRL_ONE: ctrl_one <= pwdata[7:0];
				`CONVERTER_CTRL_TWO: ctrl_two <= pwdata[7:0];
				`CHARGER_CONFIG: charger_config <= pwdata[7:0];
				`IRQ_MASK: irq_mask <= pwdata[1:0];
				default: ;
			endcase
		end
	end

	// Sticky pending flags, set wins over write-one clear
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			irq_pending <= '0;
		end else begin
			irq_pending <= (irq_pending
				& ~((wr && paddr == `IRQ_PENDING) ? pwdata[1:0] : 2'b00))
				| {cover_fall, button_rise};
		end
	end
	assign irq = |(irq_pending & ~irq_mask);

	// Read data register
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			prdata <= '0;
		end else if (rd && !penable) begin
			unique case (paddr)
				`CONVERTER_CTRL_ONE: prdata <= {24'h0, ctrl_one};
				`CONVERTER_CTRL_TWO: prdata <= {24'h0, ctrl_two};
				`CHARGER_CONFIG: prdata <= {24'h0, charger_config};
				`IRQ_PENDING: prdata <= {30'h0, irq_pending};
				`IRQ_MASK: prdata <= {30'h0, irq_mask};
				`STATUS_REG: prdata <= {21'h0, deb, 5'h0, state};
				default: prdata <= '0;
			endcase
		end
	end

	// Sleep request edge of pin AND enable bit
	assign sleep_and = s_sleep & ctrl_one[`SLEEP_ENABLE_POS];
	assign sleep_rise = sleep_and & ~sleep_and_prev;
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			sleep_and_prev <= 1'b0;
		end else begin
			sleep_and_prev <= sleep_and;
		end
	end

	// Power state machine
	// Off waits for a debounced cover and captured straps
	// Ramp states give one cycle per converter in the chosen order
	// Sleep or wait is picked by control one bit 1 on a fresh edge
	// Cover removal overrides the on and sleep states
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			state <= pseq_pkg::st_off;
			step <= 2'h0;
		end else begin
			unique case (state)
				pseq_pkg::st_off: if (deb[2] && straps_taken)
					state <= pseq_pkg::st_ramp_first;
				pseq_pkg::st_ramp_first: state <= pseq_pkg::st_ramp_second;
				pseq_pkg::st_ramp_second: state <= pseq_pkg::st_on;
				pseq_pkg::st_on: begin
					if (!deb[2]) begin
						state <= pseq_pkg::st_off;
					end else if (sleep_rise) begin
						// Wait entry needs allow bit when a supply is present
						if (!ctrl_one[1] && (!s_supply
							|| charger_config[`WAIT_ALLOW_POS])) begin
							state <= pseq_pkg::st_wait;
						end else if (ctrl_one[1]) begin
							state <= pseq_pkg::st_sleep;
						end
					end
				end
				pseq_pkg::st_sleep: begin
					if (!deb[2]) begin
						state <= pseq_pkg::st_off;
					end else if (!sleep_and || button_rise || restart_fall) begin
						state <= pseq_pkg::st_on;
					end
				end
				pseq_pkg::st_wait: if (button_rise || restart_fall)
					state <= pseq_pkg::st_ramp_first;
				default: state <= pseq_pkg::st_off;
			endcase
			step <= 2'h0;
		end
	end

	// Core voltage select: saved on sleep entry, restored on exit to on
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			saved_vsel <= `VSEL_CORE_1V5;
			core_vsel <= `VSEL_CORE_1V5;
		end else if (!straps_taken) begin
			core_vsel <= sync_b[0] ? `VSEL_CORE_1V8
				: `VSEL_CORE_1V5;
		end else if (state == pseq_pkg::st_on && sleep_rise
				&& ctrl_one[1]) begin
			saved_vsel <= core_vsel;
			core_vsel <= ctrl_two[`SLEEP_VSEL_HI:`SLEEP_VSEL_LO];
		end else if (state == pseq_pkg::st_sleep && deb[2]
				&& (!sleep_and || button_rise || restart_fall)) begin
			core_vsel <= saved_vsel;
		end
	end

	// Rail enables follow the state and the order select
	assign first_core = ~s_seq;
	always_comb begin
		rails.core_vsel = core_vsel;
		rails.main_vsel = main_vsel;
		rails.ldo_reduced = ~deb[2] | (state == pseq_pkg::st_sleep);
		unique case (state)
			pseq_pkg::st_ramp_first: begin
				rails.core_en = first_core;
				rails.main_en = ~first_core;
			end
			pseq_pkg::st_ramp_second, pseq_pkg::st_on: begin
				rails.core_en = 1'b1;
				rails.main_en = 1'b1;
			end
			pseq_pkg::st_sleep: begin
				rails.core_en = ~ctrl_two[`SLEEP_CORE_OFF_POS];
				rails.main_en = 1'b1;
			end
			default: begin
				rails.core_en = 1'b0;
				rails.main_en = 1'b0;
			end
		endcase
	end

	// Power-on reset timer after main rail good
	// Restarts from zero whenever the main rail drops or is disabled
	// Delay length picked by the delay select pin at each count
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			por_count <= '0;
			por_done <= 1'b0;
		end else if (!s_main_good || !rails.main_en) begin
			por_count <= '0;
			por_done <= 1'b0;
		end else if (!por_done) begin
			if (por_count == 32'((poweron_delay_select ? POR_LONG_CYCLES
				: POR_SHORT_CYCLES) - 1)) begin
				por_done <= 1'b1;
			end else begin
				por_count <= por_count + 32'h1;
			end
		end
	end

	// Reset and fail outputs
	// Restart resets the processor only while the core rail is good
	// Everything stays low until the power-on timer has run out
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			poweron_reset_n <= 1'b0;
			processor_reset_n <= 1'b0;
			power_fail_n <= 1'b0;
		end else begin
			poweron_reset_n <= por_done;
			processor_reset_n <= por_done
				& ~(~deb[1] & s_core_good);
			power_fail_n <= por_done & deb[2];
		end
	end
endmodule // power_sequence_sleep_control

// [pseq_map.svh]
// Register offsets, field positions, reset values and timing counts
`ifndef PSEQ_MAP_SVH
`define PSEQ_MAP_SVH
`define CONVERTER_CTRL_ONE 12'h000
`define CONVERTER_CTRL_TWO 12'h004
`define CHARGER_CONFIG 12'h008
`define IRQ_PENDING 12'h00c
`define IRQ_MASK 12'h010
`define STATUS_REG 12'h014
`define SLEEP_ENABLE_POS 0
`define SLEEP_CORE_OFF_POS 2
`define SLEEP_VSEL_LO 0
`define SLEEP_VSEL_HI 1
`define WAIT_ALLOW_POS 7
`define IRQ_BUTTON_POS 0
`define IRQ_COVER_POS 1
`define CTRL_ONE_RESET 8'h00
`define CTRL_TWO_RESET 8'h00
`define CHARGER_RESET 8'h00
`define MASK_RESET 8'h03
`define CLK_HZ 10000000
`define POR_SHORT_MS 100
`define POR_LONG_MS 1000
`define POR_SHORT_CYC ((`CLK_HZ / 1000) * `POR_SHORT_MS)
`define POR_LONG_CYC ((`CLK_HZ / 1000) * `POR_LONG_MS)
`define DEBOUNCE_CYC 1000
`define VSEL_CORE_1V5 2'h0
`define VSEL_CORE_1V8 2'h1
`define VSEL_MAIN_3V0 1'b0
`define VSEL_MAIN_3V3 1'b1
`endif

// [pseq_pkg.sv]
// Types shared by the power sequencer
package pseq_pkg;
	typedef enum logic [2:0] {
		st_off, st_ramp_first, st_ramp_second, st_on, st_sleep, st_wait
	} seq_state_t;
	typedef struct packed {
		logic core_en;
		logic main_en;
		logic [1:0] core_vsel;
		logic main_vsel;
		logic ldo_reduced;
	} rail_ctrl_t;
endpackage

// [pseq_checker_props.sv]
// Checker on sequencing, reset and pin supervision
`timescale 1ns/1ps
module pseq_checker #(
	parameter int DEBOUNCE_CYCLES = 4,
	parameter int POR_SHORT_CYCLES = 20,
	parameter int POR_LONG_CYCLES = 40
) (
	input wire logic pclk,
	input wire logic presetn,
	input wire logic psel,
	input wire logic penable,
	input wire logic pwrite,
	input wire logic pready,
	input wire logic pslverr,
	input wire logic sequence_order_select,
	input wire logic poweron_delay_select,
	input wire logic pushbutton_wake,
	input wire logic warm_restart_n,
	input wire logic cover_present,
	input wire logic core_good,
	input wire logic main_good,
	input wire pseq_pkg::rail_ctrl_t rails,
	input wire logic poweron_reset_n,
	input wire logic processor_reset_n,
	input wire logic power_fail_n,
	input wire logic irq
);
	int btn_cnt, low_cnt, rst_cnt, good_cnt;
	// Runs of unchanged raw pin levels
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			btn_cnt <= 0;
			low_cnt <= 0;
			rst_cnt <= 0;
			good_cnt <= 0;
		end else begin
			btn_cnt <= pushbutton_wake ? btn_cnt + 1 : 0;
			low_cnt <= cover_present ? 0 : low_cnt + 1;
			rst_cnt <= warm_restart_n ? 0 : rst_cnt + 1;
			good_cnt <= main_good ? good_cnt + 1 : 0;
		end
	end
	default clocking @(posedge pclk); endclocking
	default disable iff (!presetn);
	sequence apb_access;
		psel && penable;
	endsequence
	sequence irq_from_pin;
		$rose(irq) && !$past(psel && pwrite);
	endsequence
	apb_answer_a: assert property (apb_access |-> pready && !pslverr)
		else $error("bus answer late or in error");
	core_first_a: assert property (
		!sequence_order_select && $rose(rails.main_en) |-> rails.core_en)
		else $error("main rail rose before core rail");
	main_first_a: assert property (
		sequence_order_select && $rose(rails.core_en) |-> rails.main_en)
		else $error("core rail rose before main rail");
	por_delay_a: assert property ($rose(poweron_reset_n) |->
		good_cnt >= (poweron_delay_select ? POR_LONG_CYCLES : POR_SHORT_CYCLES))
		else $error("power-on reset released early");
	reset_follow_a: assert property (
		!poweron_reset_n |-> !processor_reset_n)
		else $error("processor reset free during power-on reset");
	debounce_a: assert property (irq_from_pin |->
		btn_cnt >= DEBOUNCE_CYCLES || low_cnt >= DEBOUNCE_CYCLES)
		else $error("interrupt from an undebounced pin");
	cover_fail_a: assert property (
		low_cnt > DEBOUNCE_CYCLES + 4 |-> !power_fail_n)
		else $error("power fail not low with cover removed");
	cover_off_a: assert property (low_cnt > DEBOUNCE_CYCLES + 10 |->
		!rails.core_en && !rails.main_en && rails.ldo_reduced)
		else $error("rails still up with cover removed");
	restart_a: assert property (rst_cnt > DEBOUNCE_CYCLES + 4 &&
		core_good && $past(core_good, 4) |-> !processor_reset_n)
		else $error("no processor reset on warm restart");
	irq_reset_a: assert property ($rose(presetn) |-> !irq)
		else $error("interrupt unmasked after reset");
endmodule // pseq_checker
bind power_sequence_sleep_control pseq_checker #(
	.DEBOUNCE_CYCLES(DEBOUNCE_CYCLES),
	.POR_SHORT_CYCLES(POR_SHORT_CYCLES),
	.POR_LONG_CYCLES(POR_LONG_CYCLES)
) chk_u (.*);

// [rail_host_model.sv]
// Model of rail feedback and of the host sleep request
`timescale 1ns/1ps
module rail_host_model (
	input wire logic pclk,
	input wire logic presetn,
	input wire pseq_pkg::rail_ctrl_t rails,
	input wire logic sleep_cmd,
	output logic core_good,
	output logic main_good,
	output logic sleep_request_pin
);
	// Rails report good one cycle after enable, drop one cycle after it
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			core_good <= 1'b0;
			main_good <= 1'b0;
		end else begin
			core_good <= rails.core_en;
			main_good <= rails.main_en;
		end
	end
	// Host pin follows the sleep command one cycle later
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			sleep_request_pin <= 1'b0;
		end else begin
			sleep_request_pin <= sleep_cmd;
		end
	end
endmodule // rail_host_model

// [power_sequence_sleep_control_tb.sv]
// Self-checking bench for the power sequencer
`timescale 1ns/1ps
`include "pseq_map.svh"
`define CHK(a, b) begin num_checks++; if ((a) !== (b)) begin \
	fail_count++; $display("CHECK FAILED %0t got %h", $time, a); end end
module power_sequence_sleep_control_tb;
	logic pclk = 1'b0, presetn = 1'b0, psel = 1'b0, penable = 1'b0;
	logic pwrite = 1'b0, pready, pslverr, irq, sleep_request_pin, sleep_cmd = 1'b0;
	logic [11:0] paddr = 12'h000;
	logic [31:0] pwdata = 32'h0, prdata, q;
	logic sequence_order_select = 1'b0, core_default_select = 1'b0;
	logic main_default_select = 1'b0, poweron_delay_select = 1'b0;
	logic pushbutton_wake = 1'b0, warm_restart_n = 1'b1, cover_present = 1'b1;
	logic supply_present = 1'b0, core_good, main_good;
	logic poweron_reset_n, processor_reset_n, power_fail_n;
	logic [1:0] v;
	pseq_pkg::rail_ctrl_t rails;
	int fail_count = 0, num_checks = 0;
	power_sequence_sleep_control #(.DEBOUNCE_CYCLES(4),
		.POR_SHORT_CYCLES(20), .POR_LONG_CYCLES(40)) dut_u (.*);
	rail_host_model model_u (.*);
	// Clock of 100 ns period
	always #50 pclk = ~pclk;
	// One bus transfer, held until ready is sampled
	task automatic apb(input logic wr, input logic [11:0] a, input logic [31:0] d);
		@(posedge pclk);
		psel <= 1'b1;
		pwrite <= wr;
		paddr <= a;
		pwdata <= d;
		@(posedge pclk);
		penable <= 1'b1;
		for (int i = 0; i < 20; i++) begin
			@(posedge pclk);
			if (pready === 1'b1) break;
		end
		`CHK(pready, 1'b1)
		q = prdata;
		psel <= 1'b0;
		penable <= 1'b0;
	endtask
	// Poll the status state field, bounded
	task automatic wait_state(input pseq_pkg::seq_state_t s);
		for (int i = 0; i < 60; i++) begin
			apb(1'b0, `STATUS_REG, 32'h0);
			if (q[2:0] === s) break;
		end
		`CHK(q[2:0], s)
	endtask
	// Pin level held for a given number of cycles
	task automatic hold(int n);
		repeat (n) @(posedge pclk);
	endtask
	task automatic tally_and_finish;
		$display("checks %0d mismatches %0d", num_checks, fail_count);
		if (fail_count == 0 && num_checks > 0) $display("ALL TESTS PASSED");
		else $display("TESTS FAILED");
		$finish;
	endtask
	// Main sequence
	initial begin
		void'($urandom(32'h4d24));
		@(posedge pclk);
		sequence_order_select <= $urandom;
		core_default_select <= $urandom;
		main_default_select <= $urandom;
		poweron_delay_select <= $urandom;
		v = $urandom;
		hold(10);
		presetn <= 1'b1;
		for (int i = 0; i < 300 && poweron_reset_n !== 1'b1; i++) hold(1);
		`CHK(poweron_reset_n, 1'b1)
		`CHK(rails.core_vsel, core_default_select ? 2'h1 : 2'h0)
		`CHK(rails.main_vsel, main_default_select)
		$display("power-up test done");
		sleep_cmd <= 1'b1;
		hold(10);
		wait_state(pseq_pkg::st_on);
		apb(1'b1, `CONVERTER_CTRL_TWO, {30'h0, v});
		apb(1'b1, `CONVERTER_CTRL_ONE, 32'h3);
		wait_state(pseq_pkg::st_sleep);
		`CHK(rails.core_vsel, v)
		sleep_cmd <= 1'b0;
		wait_state(pseq_pkg::st_on);
		sleep_cmd <= 1'b1;
		wait_state(pseq_pkg::st_sleep);
		pushbutton_wake <= 1'b1;
		hold(12);
		pushbutton_wake <= 1'b0;
		wait_state(pseq_pkg::st_on);
		`CHK(rails.core_vsel, core_default_select ? 2'h1 : 2'h0)
		hold(10);
		wait_state(pseq_pkg::st_on);
		`CHK(irq, 1'b0)
		apb(1'b1, `IRQ_MASK, 32'h0);
		hold(1);
		`CHK(irq, 1'b1)
		apb(1'b1, `IRQ_PENDING, 32'h1);
		hold(1);
		`CHK(irq, 1'b0)
		$display("sleep and button test done");
		sleep_cmd <= 1'b0;
		apb(1'b1, `CONVERTER_CTRL_TWO, 32'h4);
		sleep_cmd <= 1'b1;
		wait_state(pseq_pkg::st_sleep);
		`CHK(rails.core_en, 1'b0)
		apb(1'b1, `CONVERTER_CTRL_ONE, 32'h2);
		wait_state(pseq_pkg::st_on);
		apb(1'b1, `CONVERTER_CTRL_ONE, 32'h3);
		wait_state(pseq_pkg::st_sleep);
		warm_restart_n <= 1'b0;
		hold(20);
		warm_restart_n <= 1'b1;
		wait_state(pseq_pkg::st_on);
		apb(1'b0, `CONVERTER_CTRL_ONE, 32'h0);
		`CHK(q[7:0], 8'h03)
		$display("restart test done");
		apb(1'b1, `CONVERTER_CTRL_ONE, 32'h0);
		apb(1'b1, `CONVERTER_CTRL_ONE, 32'h1);
		wait_state(pseq_pkg::st_wait);
		`CHK(rails.main_en, 1'b0)
		pushbutton_wake <= 1'b1;
		hold(12);
		pushbutton_wake <= 1'b0;
		wait_state(pseq_pkg::st_on);
		$display("wait test done");
		cover_present <= 1'b0;
		wait_state(pseq_pkg::st_off);
		`CHK(power_fail_n, 1'b0)
		`CHK(irq, 1'b1)
		`CHK(rails.main_en, 1'b0)
		$display("cover test done");
		tally_and_finish();
	end
endmodule // power_sequence_sleep_control_tb
